// file: status_pin_pkg.sv
`default_nettype none
package status_pin_pkg;
  localparam int pin_count = 4;
  localparam int func_width = 4;
  // Pin function codes held in the configuration store
  localparam logic [3:0] func_tristate = 4'h0;
  localparam logic [3:0] func_tx_led = 4'h1;
  localparam logic [3:0] func_rx_led = 4'h2;
  localparam logic [3:0] func_any_led = 4'h3;
  localparam logic [3:0] func_charger = 4'h4;
  localparam logic [3:0] func_charger_n = 4'h5;
  localparam logic [3:0] func_suspend_n = 4'h6;
  localparam logic [3:0] func_power_enable_n = 4'h7;
  // Configuration store layout: one word per pin at these word addresses
  localparam logic [7:0] config_base_addr = 8'h00;
  localparam logic [7:0] config_last_addr = 8'h03;
  localparam int config_addr_width = 8;
  localparam int config_data_width = 16;
  // Function code field of each configuration word
  localparam int func_field_lsb = 0;
  // One-shot stretch time and derived clock count
  localparam int clk_period_ns = 100;
  localparam int stretch_time_us = 50;
  localparam int stretch_cycles = (stretch_time_us * 1000) / clk_period_ns;
  localparam int stretch_width = 10;
  localparam logic [3:0] func_reset_value = 4'h0;
endpackage : status_pin_pkg
`default_nettype wire

// file: activity_one_shot.sv
`default_nettype none
module activity_one_shot
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic activity,
  output logic stretched
);
  typedef struct packed {
    logic [status_pin_pkg::stretch_width-1:0] count;
  } state_type;
  state_type state_reg;
  state_type state_next;

  always_comb
  begin
    state_next = state_reg;
    if (activity)
      state_next.count = status_pin_pkg::stretch_width'(status_pin_pkg::stretch_cycles); // [R13]
    else if (state_reg.count != '0)
      state_next.count = state_reg.count - 1'b1; // [R7]
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign stretched = (state_reg.count != '0);
endmodule // activity_one_shot
`default_nettype wire

// file: status_pin_indicators.sv
`default_nettype none
// Summary of operation
// R1 - Charger-detect asserts when a dedicated charge port is seen while suspended.
// R2 - Charger-detect function available active high or active low per pin.
// R3 - Dedicated charge port attachment forces the suspended state, no enumeration.
// R4 - Enumerated and not suspended keeps charger-detect inactive.
// R5 - Any pin may carry transmit, receive or combined activity LED.
// R6 - LED pins float while idle and drive low during activity.
// R7 - Each LED indication is stretched by a one-shot to stay visible.
// R8 - Combined LED asserts on transmit or receive activity.
// R9 - After power-on or bus reset the configuration store is scanned.
// R10 - Each pin's function comes from the configuration store.
// R11 - Suspend indicator drives low while suspended, high otherwise.
// R12 - Power-enable drives high while suspended, low when active.
// R13 - Stretch length is a fixed cycle count and retriggers on activity.
// R14 - All pins float until the configuration load completes.
module status_pin_indicators
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic usb_bus_reset,
  input wire logic bus_suspended,
  input wire logic data_lines_shorted,
  input wire logic tx_activity,
  input wire logic rx_activity,
  output logic [status_pin_pkg::config_addr_width-1:0] config_addr,
  output logic config_read,
  input wire logic [status_pin_pkg::config_data_width-1:0] config_data,
  input wire logic config_data_valid,
  output logic device_suspended,
  output logic config_loaded,
  output logic [status_pin_pkg::pin_count-1:0] configurable_status_pins_out,
  output logic [status_pin_pkg::pin_count-1:0] configurable_status_pins_oe
);
  typedef enum
  {
    scan_idle,
    scan_request,
    scan_wait,
    scan_done
  } scan_state_type;

  typedef struct packed {
    scan_state_type scan;
    logic [status_pin_pkg::config_addr_width-1:0] addr;
    logic read;
    logic [status_pin_pkg::pin_count-1:0][status_pin_pkg::func_width-1:0] func;
    logic loaded;
    logic suspended;
    logic charge_port;
    logic [status_pin_pkg::pin_count-1:0] pin_out;
    logic [status_pin_pkg::pin_count-1:0] pin_oe;
  } state_type;

  state_type state_reg;
  state_type state_next;
  logic tx_stretched;
  logic rx_stretched;
  logic any_stretched;

  activity_one_shot tx_shot
  (
    .clk(clk),
    .nrst(nrst),
    .activity(tx_activity),
    .stretched(tx_stretched)
  );

  activity_one_shot rx_shot
  (
    .clk(clk),
    .nrst(nrst),
    .activity(rx_activity),
    .stretched(rx_stretched)
  );

  // Own one-shot so the combined LED retriggers on either direction
  activity_one_shot any_shot
  (
    .clk(clk),
    .nrst(nrst),
    .activity(tx_activity || rx_activity),
    .stretched(any_stretched)
  );

  // Activity LED: sink current while active, float otherwise
  function automatic logic [1:0] led_drive(input logic active);
    logic [1:0] drive;
    drive = 2'b00;
    if (active)
    begin
      drive = 2'b10; // [R6]
    end
    else
    begin
      drive = 2'b00;
    end
    return drive;
  endfunction

  // Level functions always drive the pin once configured
  function automatic logic [1:0] level_drive(input logic level);
    logic [1:0] drive;
    drive = {1'b1, level};
    return drive;
  endfunction

  // Charger detect only while suspended on a charge port
  function automatic logic charger_seen(input logic charge, input logic suspended);
    logic seen;
    seen = charge && suspended; // [R1] [R4]
    return seen;
  endfunction

  // Word address that follows the current one in the scan
  function automatic logic [status_pin_pkg::config_addr_width-1:0] scan_addr_after(
    input logic [status_pin_pkg::config_addr_width-1:0] addr);
    logic [status_pin_pkg::config_addr_width-1:0] next_addr;
    next_addr = addr + {{(status_pin_pkg::config_addr_width-1){1'b0}}, 1'b1};
    return next_addr;
  endfunction

  // True when the word just read belongs to the last pin
  function automatic logic scan_is_last(
    input logic [status_pin_pkg::config_addr_width-1:0] addr);
    logic last;
    last = (addr == status_pin_pkg::config_last_addr);
    return last;
  endfunction

  // Function code field of a configuration word
  function automatic logic [status_pin_pkg::func_width-1:0] func_of_word(
    input logic [status_pin_pkg::config_data_width-1:0] word);
    logic [status_pin_pkg::func_width-1:0] code;
    code = word[status_pin_pkg::func_field_lsb +: status_pin_pkg::func_width]; // [R10]
    return code;
  endfunction

  // One word per pin, so the word offset is the pin index
  function automatic logic [1:0] pin_of_addr(
    input logic [status_pin_pkg::config_addr_width-1:0] addr);
    logic [1:0] pin;
    pin = 2'(addr - status_pin_pkg::config_base_addr);
    return pin;
  endfunction

  // Old codes survive a bus reset, so the load flag gates every pin
  function automatic logic [1:0] gate_drive(input logic [1:0] drive, input logic loaded,
                                            input logic bus_reset);
    logic [1:0] gated;
    gated = drive;
    if (!loaded || bus_reset)
    begin
      gated = 2'b00; // [R14]
    end
    return gated;
  endfunction

  // Map a function code to the pin's next drive: {oe, out}
  function automatic logic [1:0] pin_drive(input logic [3:0] func, input logic suspended,
                                           input logic charge, input logic tx_on,
                                           input logic rx_on, input logic any_on);
    logic [1:0] drive;
    drive = 2'b00;
    unique case (func)
      status_pin_pkg::func_tx_led:
      begin
        drive = led_drive(tx_on); // [R5] [R6]
      end
      status_pin_pkg::func_rx_led:
      begin
        drive = led_drive(rx_on); // [R5] [R6]
      end
      status_pin_pkg::func_any_led:
      begin
        drive = led_drive(any_on); // [R5] [R8]
      end
      status_pin_pkg::func_charger:
      begin
        drive = level_drive(charger_seen(charge, suspended)); // [R1] [R2]
      end
      status_pin_pkg::func_charger_n:
      begin
        drive = level_drive(!charger_seen(charge, suspended)); // [R2] [R4]
      end
      status_pin_pkg::func_suspend_n:
      begin
        drive = level_drive(!suspended); // [R11]
      end
      status_pin_pkg::func_power_enable_n:
      begin
        drive = level_drive(suspended); // [R12]
      end
      default:
      begin
        // Tristate and unused codes leave the pin floating
        drive = 2'b00;
      end
    endcase
    return drive;
  endfunction

  always_comb
  begin
    logic [1:0] drive;
    drive = 2'b00;
    state_next = state_reg;
    state_next.read = 1'b0;

    // Shorted data lines mean a charge port: suspend instead of enumerating
    state_next.charge_port = data_lines_shorted;
    if (data_lines_shorted)
    begin
      state_next.suspended = 1'b1; // [R3]
    end
    else
    begin
      state_next.suspended = bus_suspended; // [R4]
    end

    // Scan reads one word per pin, one outstanding read at a time
    unique case (state_reg.scan)
      scan_idle:
      begin
        state_next.addr = status_pin_pkg::config_base_addr; // [R9]
        state_next.scan = scan_request;
      end
      scan_request:
      begin
        state_next.read = 1'b1; // [R9]
        state_next.scan = scan_wait;
      end
      scan_wait:
      begin
        // The store may take any number of cycles; wait for its strobe
        if (config_data_valid)
        begin
          state_next.func[pin_of_addr(state_reg.addr)] = func_of_word(config_data); // [R10]
          if (scan_is_last(state_reg.addr))
          begin
            state_next.scan = scan_done;
            state_next.loaded = 1'b1; // [R14]
          end
          else
          begin
            state_next.addr = scan_addr_after(state_reg.addr);
            state_next.scan = scan_request;
          end
        end
      end
      scan_done:
      begin
        // Held until a bus reset or nrst restarts the scan
        state_next.scan = scan_done;
      end
    endcase

    // Bus reset restarts the scan; pins float again until it ends
    if (usb_bus_reset)
    begin
      state_next.scan = scan_idle; // [R9]
      state_next.loaded = 1'b0;
      state_next.read = 1'b0;
    end

    // Pins follow the registered codes, one cycle behind the one-shots
    for (int i = 0; i < status_pin_pkg::pin_count; i++)
    begin
      drive = pin_drive(state_reg.func[i], state_reg.suspended, state_reg.charge_port,
                        tx_stretched, rx_stretched, any_stretched);
      drive = gate_drive(drive, state_reg.loaded, usb_bus_reset);
      state_next.pin_oe[i] = drive[1];
      state_next.pin_out[i] = drive[0];
    end
  end

  // Reset floats every pin and restarts the scan
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg.scan <= scan_idle; // [R9]
      state_reg.addr <= '0;
      state_reg.read <= 1'b0;
      state_reg.func <= {status_pin_pkg::pin_count{status_pin_pkg::func_reset_value}};
      state_reg.loaded <= 1'b0;
      state_reg.suspended <= 1'b0;
      state_reg.charge_port <= 1'b0;
      state_reg.pin_out <= '0;
      state_reg.pin_oe <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Every output is a register field
  assign config_addr = state_reg.addr;
  assign config_read = state_reg.read;
  assign device_suspended = state_reg.suspended;
  assign config_loaded = state_reg.loaded;
  assign configurable_status_pins_out = state_reg.pin_out;
  assign configurable_status_pins_oe = state_reg.pin_oe;
endmodule // status_pin_indicators
`default_nettype wire

// file: status_pin_properties.sv
`default_nettype none
module status_pin_properties
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic usb_bus_reset,
  input wire logic bus_suspended,
  input wire logic data_lines_shorted,
  input wire logic config_read,
  input wire logic config_loaded,
  input wire logic device_suspended,
  input wire logic [status_pin_pkg::pin_count-1:0] configurable_status_pins_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_short_suspends: assert property (data_lines_shorted |=> device_suspended)
    else $error("no suspend on charge port");
  a_active_clear: assert property (!bus_suspended && !data_lines_shorted |=> !device_suspended)
    else $error("suspended while active");
  a_read_single: assert property (config_read |=> !config_read)
    else $error("read strobe too long");
  a_reset_reload: assert property (usb_bus_reset |=> !config_loaded)
    else $error("bus reset kept config");
  a_load_bound: assert property ($fell(usb_bus_reset) |-> ##[1:100] config_loaded)
    else $error("reload too slow");
  a_reset_float: assert property (usb_bus_reset |=> configurable_status_pins_oe == '0)
    else $error("pin driven in bus reset");
  a_unloaded_float: assert property (!config_loaded && !$past(config_loaded) |->
    configurable_status_pins_oe == '0) else $error("pin driven before load");
  a_loaded_holds: assert property (config_loaded && !usb_bus_reset |=> config_loaded)
    else $error("config lost");
  cover property ($rose(config_loaded));
  cover property (data_lines_shorted ##2 device_suspended);
  cover property (usb_bus_reset ##1 !usb_bus_reset);
endmodule // status_pin_properties
`default_nettype wire

// file: config_store_model.sv
`default_nettype none
module config_store_model
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] config_addr,
  input wire logic config_read,
  input wire logic [63:0] words,
  input wire logic [2:0] delay,
  output logic [15:0] config_data,
  output logic config_data_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic [7:0] a;
  always @(posedge clk or negedge nrst)
  begin
    config_data_valid <= 1'b0;
    // Data toggles off the answer cycle so a stale word cannot pass
    config_data <= ~config_data;
    if (!nrst)
    begin
      cnt <= -1;
      config_data <= 16'h0000;
    end
    else if (config_read)
    begin
      cnt <= delay;
      a <= config_addr;
    end
    else if (cnt == 0)
    begin
      config_data_valid <= 1'b1;
      config_data <= words[a[1:0]*16 +: 16];
      cnt <= -1;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule // config_store_model
`default_nettype wire

// file: status_pin_indicators_tb_top.sv
`default_nettype none
module status_pin_indicators_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, usb_bus_reset = 0, bus_suspended = 0, data_lines_shorted = 0;
  logic tx_activity = 0, rx_activity = 0, config_read, config_data_valid;
  logic device_suspended, config_loaded;
  logic [7:0] config_addr, q[$];
  logic [15:0] config_data;
  logic [3:0] configurable_status_pins_out, configurable_status_pins_oe;
  logic [63:0] words = 0;
  logic [2:0] delay = 0;
  int n_errors = 0, tests_run = 0;
  status_pin_indicators u_status_pin_indicators(.*);
  config_store_model u_config_store_model(.*);
  initial forever #50 clk = ~clk;
  function automatic logic [15:0] w(input logic [3:0] c);
    return {12'($urandom), c};
  endfunction
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task ex(input logic [7:0] e);
    q.push_back(e);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] %0t pins %h expected %h", $time, s, e);
    end
  endtask
  task wait_ld;
    for (int i = 0; i < 200 && config_loaded !== 1'b1; i++)
      @(negedge clk);
    if (config_loaded !== 1'b1)
    begin
      n_errors++;
      print_verdict;
    end
    step(1);
  endtask
  task pulse_tx;
    tx_activity = 1;
    step(1);
    tx_activity = 0;
  endtask
  task pulse_rx;
    rx_activity = 1;
    step(1);
    rx_activity = 0;
  endtask
  // Out bits of floating pins carry no meaning, so they are masked
  initial forever
  begin
    @(negedge clk);
    #1;
    while (q.size() > 0)
      chk({configurable_status_pins_oe, configurable_status_pins_out & configurable_status_pins_oe},
        q.pop_front());
  end
  initial
  begin
    void'($urandom(20));
    words = {w(status_pin_pkg::func_charger), w(status_pin_pkg::func_any_led),
      w(status_pin_pkg::func_rx_led), w(status_pin_pkg::func_tx_led)};
    delay = 3'($urandom_range(0, 6));
    step(12);
    nrst = 1;
    wait_ld;
    ex(8'h80);
    pulse_tx;
    step(3);
    ex(8'hd0);
    step(400);
    ex(8'hd0);
    step(120);
    ex(8'h80);
    pulse_rx;
    step(300);
    pulse_rx;
    step(450);
    ex(8'he0);
    step(100);
    ex(8'h80);
    data_lines_shorted = 1;
    step(4);
    ex(8'h88);
    data_lines_shorted = 0;
    bus_suspended = 1;
    step(4);
    ex(8'h80);
    bus_suspended = 0;
    words = {w(status_pin_pkg::func_tristate), w(status_pin_pkg::func_power_enable_n),
      w(status_pin_pkg::func_suspend_n), w(status_pin_pkg::func_charger_n)};
    delay = 3'($urandom_range(0, 6));
    usb_bus_reset = 1;
    step(2);
    ex(8'h00);
    usb_bus_reset = 0;
    wait_ld;
    ex(8'h73);
    data_lines_shorted = 1;
    step(4);
    ex(8'h74);
    step(2);
    print_verdict;
  end
endmodule // status_pin_indicators_tb_top
bind status_pin_indicators status_pin_properties u_status_pin_properties(.*);
`default_nettype wire
